// [logic/ttx_acq.sv]
`timescale 1ns/1ns
`default_nettype none
`include "ttx_defines.svh"

// ==========================================
// Word FIFO between slicer and acquisition
module ttx_fifo #(
   parameter int WIDTH = `TTX_FIFO_WIDTH,
   parameter int DEPTH = `TTX_FIFO_DEPTH
) (
   input wire logic clk_in,               // System clock
   input wire logic sys_rst_in,           // Synchronous reset
   input wire logic in_valid_in,          // Write request
   input wire logic [WIDTH-1:0] in_data_in, // Write word
   output logic in_ready_out,             // Room for a word
   output logic out_valid_out,            // Word available
   output logic [WIDTH-1:0] out_data_out, // Head word
   input wire logic out_ready_in          // Head consumed
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic rdy;
   } ttx_fifo_s;
   ttx_fifo_s s, n;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   assign out_valid_out = (s.cnt != '0);
   assign out_data_out = mem[s.rp];
   assign in_ready_out = s.rdy;

   always_comb begin
      n = s;
      push = in_valid_in && s.rdy;
      pop = out_valid_out && out_ready_in;
      if (push) begin
         n.wp = s.wp + 1'b1;
      end
      if (pop) begin
         n.rp = s.rp + 1'b1;
      end
      n.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      // Ready is registered so the slicer sees a flop, one slot of slack is lost
      n.rdy = (n.cnt < (AW+1)'(DEPTH - 1));
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[s.wp] <= in_data_in;
      end
   end
endmodule : ttx_fifo

// ==========================================
// Acquisition
module ttx_acq (
   input wire logic clk_in,                     // 20 MHz system clock
   input wire logic sys_rst_in,                 // Synchronous reset, high
   input wire logic byte_valid_in,              // Slicer word valid
   input wire logic byte_first_in,              // Word is the packet address byte
   input wire logic byte_page_ok_in,            // Packet belongs to a requested page
   input wire logic [7:0] byte_in,              // Slicer byte
   output logic byte_ready_out,                 // FIFO can take a word
   input wire logic field_start_in,             // Field start pulse
   input wire logic mem_wait_in,                // Page memory busy, stalls draining
   input wire logic force_select_hi_in,         // Force select high bit
   input wire logic force_select_lo_in,         // Force select low bit
   input wire logic row24_location_select_in,   // Packet 24 placement
   input wire logic raw_byte_mode_in,           // Write bytes unchecked
   input wire logic [1:0] page_check_in,        // Page-request error check bits
   input wire logic parallel_mag_in,            // Parallel magazine mode
   input wire logic [3:0] mag_select_in,        // Requested magazine
   input wire logic link_flag_clear_in,         // Software writes zero to link flag
   output logic mem_we_out,                     // Page memory write strobe
   output logic mem_ext_out,                    // Extension packet memory
   output logic [4:0] mem_row_out,              // Memory row
   output logic [5:0] mem_col_out,              // Memory column
   output logic [7:0] mem_data_out,             // Memory data
   output logic trip_valid_out,                 // Packet 26 triplet strobe
   output logic [4:0] trip_dc_out,              // Packet 26 designation code
   output logic [17:0] trip_data_out,           // Triplet data bits
   output logic timing_625_out,                 // 625-line timing selected
   output logic std_525_out,                    // 525-line teletext standard
   output logic std_high_line_detected_out,     // 625-line text decided
   output logic std_low_line_detected_out,      // 525-line text decided
   output logic link_detected_out               // Page-link packet seen
);
   ttx_pkg::ttx_acq_s s, n;
   logic f_valid;
   logic [`TTX_FIFO_WIDTH-1:0] f_word;
   logic f_ready;

   // Byte 8/4 Hamming: data in odd bit positions, bit 7 set marks a parity failure
   function automatic logic [7:0] ham84(input logic [7:0] b);
      ham84 = {~(^b), 3'h0, b[7], b[5], b[3], b[1]};
   endfunction : ham84

   // Returns write enable and the byte to store
   function automatic logic [8:0] chk(input logic [7:0] b, input logic raw, input logic [1:0] pc);
      if (raw) begin
         chk = {1'b1, b};
      end else if (pc == 2'h0) begin
         chk = {1'b1, 1'b0, b[6:0]};
      end else begin
         chk = {^b, 1'b0, b[6:0]};
      end
   endfunction : chk

   function automatic logic [17:0] trip18(input logic [23:0] t);
      trip18 = {t[23:17], t[15:9], t[7:5], t[3]};
   endfunction : trip18

   ttx_fifo #(
      .WIDTH(`TTX_FIFO_WIDTH),
      .DEPTH(`TTX_FIFO_DEPTH)
   ) u_fifo (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .in_valid_in(byte_valid_in),
      .in_data_in({byte_first_in, byte_page_ok_in, byte_in}),
      .in_ready_out(byte_ready_out),
      .out_valid_out(f_valid),
      .out_data_out(f_word),
      .out_ready_in(f_ready)
   );

   // Draining stops while the page memory is busy, so back-pressure reaches the slicer
   assign f_ready = !mem_wait_in;

   assign mem_we_out = s.we;
   assign mem_ext_out = s.ext;
   assign mem_row_out = s.row;
   assign mem_col_out = s.col;
   assign mem_data_out = s.data;
   assign trip_valid_out = s.tv;
   assign trip_dc_out = s.tdc;
   assign trip_data_out = s.tdata;
   assign timing_625_out = s.t625;
   assign std_525_out = s.s525;
   assign std_high_line_detected_out = s.hi_det;
   assign std_low_line_detected_out = s.lo_det;
   assign link_detected_out = s.link_flag;

   always_comb begin
      logic [7:0] b;
      logic [8:0] ck;
      logic [7:0] hm;
      logic [5:0] lim;
      logic [1:0] frc;
      n = s;
      b = f_word[7:0];
      ck = chk(b, raw_byte_mode_in, page_check_in);
      hm = ham84(b);
      lim = s.s525 ? `TTX_DATA_525 : `TTX_DATA_625;
      frc = {force_select_hi_in, force_select_lo_in};
      n.we = 1'b0;
      n.tv = 1'b0;
      n.force_prev = frc;

      // ==========================================
      // Standard selection and detection
      if (field_start_in) begin
         n.seen = 1'b0;
         if (s.seen) begin
            n.decided = 1'b1;
            n.miss = 4'h0;
         end else if (s.miss == `TTX_DET_FIELDS - 4'd1) begin
            n.auto525 = !s.auto525;
            n.decided = 1'b0;
            n.miss = 4'h0;
         end else begin
            n.miss = s.miss + 4'd1;
         end
      end
      if (frc != s.force_prev) begin
         n.decided = 1'b0;
         n.miss = 4'h0;
      end
      case (frc)
         2'b01: begin
            n.t625 = 1'b0;
            n.s525 = 1'b1;
         end
         2'b10: begin
            n.t625 = 1'b1;
            n.s525 = 1'b0;
         end
         2'b11: begin
            n.t625 = 1'b1;
            n.s525 = 1'b1;
         end
         default: begin
            n.t625 = !s.auto525;
            n.s525 = s.auto525;
         end
      endcase
      // Forced settings count as a decision so software sees the chosen standard
      if (frc != 2'b00) begin
         n.hi_det = !n.s525;
         n.lo_det = n.s525;
      end else begin
         n.hi_det = n.decided && !n.s525;
         n.lo_det = n.decided && n.s525;
      end

      if (link_flag_clear_in) begin
         n.link_flag = 1'b0;
      end

      // ==========================================
      // Packet processing
      if (f_valid && f_ready) begin
         if (f_word[9]) begin
            n.seen = 1'b1;
            n.st = ttx_pkg::ST_DATA;
            n.idx = 6'h0;
            n.pok = f_word[8];
            n.pnum = b[4:0];
            if (s.s525) begin
               n.tab = b[7];
               n.mag = (b[6:5] == 2'h0) ? `TTX_MAG_BSD_525 : {2'h0, b[6:5]};
            end else begin
               n.tab = 1'b0;
               n.mag = (b[7:5] == 3'h0) ? `TTX_MAG_BSD_625 : {1'b0, b[7:5]};
            end
            n.rok = !parallel_mag_in || (n.mag == mag_select_in);
            if (n.pnum == 5'h0) begin
               n.kind = ttx_pkg::K_SKIP;
            end else if (n.pnum <= `TTX_PKT_TAB_LAST) begin
               n.kind = n.tab ? ttx_pkg::K_TAB : ttx_pkg::K_ROW;
            end else if (n.pnum == `TTX_PKT_X24) begin
               n.kind = n.tab ? ttx_pkg::K_X124 : ttx_pkg::K_X24;
            end else if (n.pnum == `TTX_PKT_X26) begin
               n.kind = ttx_pkg::K_X26;
            end else if (n.pnum == `TTX_PKT_X27) begin
               n.kind = n.tab ? ttx_pkg::K_SKIP : ttx_pkg::K_X27;
            end else if (n.pnum == `TTX_PKT_X30
                         && n.mag == (s.s525 ? `TTX_MAG_BSD_525 : `TTX_MAG_BSD_625)) begin
               n.kind = ttx_pkg::K_X30;
            end else begin
               n.kind = ttx_pkg::K_SKIP;
            end
         end else if (s.st == ttx_pkg::ST_DATA && s.idx < lim) begin
            n.idx = s.idx + 6'd1;
            n.data = ck[7:0];
            case (s.kind)
               ttx_pkg::K_ROW: begin
                  n.we = s.pok && ck[8];
                  n.ext = 1'b0;
                  n.row = s.pnum;
                  n.col = s.idx;
               end
               ttx_pkg::K_TAB: begin
                  n.ext = 1'b0;
                  n.row = {s.pnum[4:2], 2'b00} + {3'h0, s.idx[4:3]};
                  n.col = `TTX_TAB_COL + {3'h0, s.idx[2:0]};
                  // Row 0 columns 32..39 are the rolling time, taken from any page, in parallel magazine mode only of mag_select_in
                  n.we = ck[8] && ((n.row == 5'h0) ? s.rok : s.pok);
               end
               ttx_pkg::K_X24, ttx_pkg::K_X124: begin
                  n.we = s.pok && ck[8] && (s.kind == ttx_pkg::K_X24 || s.idx < `TTX_TAB_BYTES);
                  n.ext = !row24_location_select_in;
                  n.row = row24_location_select_in ? `TTX_ROW24 : `TTX_EXT_ROW_X24;
                  n.col = (s.kind == ttx_pkg::K_X124) ? `TTX_TAB_COL + s.idx : s.idx;
               end
               ttx_pkg::K_X27: begin
                  if (s.idx == 6'h0) begin
                     if (hm != 8'h0) begin
                        n.kind = ttx_pkg::K_SKIP;
                     end else begin
                        n.link_flag = 1'b1;
                     end
                  end else begin
                     n.we = s.pok;
                     n.ext = 1'b1;
                     n.row = `TTX_EXT_ROW_LINKS;
                     n.col = s.idx - 6'd1;
                     n.data = hm;
                  end
               end
               ttx_pkg::K_X30: begin
                  n.we = 1'b1;
                  n.ext = 1'b1;
                  if (s.idx < `TTX_BSD_BYTES) begin
                     n.row = `TTX_EXT_ROW_BSD;
                     n.col = s.idx;
                     n.data = hm;
                  end else begin
                     n.row = `TTX_EXT_ROW_STAT;
                     n.col = s.idx - `TTX_BSD_BYTES + (s.tab ? `TTX_STAT_HALF : 6'h0);
                     n.data = b;
                     // Two halves give 24 bytes at 525 lines (625 has one half of 20) but the message has 20 places; the 525 tail is dropped
                     n.we = (n.col < `TTX_STAT_LEN);
                  end
               end
               ttx_pkg::K_X26: begin
                  if (s.idx == 6'h0) begin
                     n.dc = {s.tab, hm[3:0]};
                  end else if (s.idx <= (s.s525 ? `TTX_TRIP_LAST_525 : `TTX_TRIP_LAST_625)) begin
                     n.tacc = {b, s.tacc[15:8]};
                     if ((s.idx % 6'd3) == 6'h0) begin
                        n.tv = s.pok;
                        n.tdc = s.dc;
                        n.tdata = trip18({b, s.tacc});
                     end
                  end
               end
               default: begin
                  n.we = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
endmodule : ttx_acq
`default_nettype wire

// [include/ttx_defines.svh]
`ifndef TTX_DEFINES_SVH
`define TTX_DEFINES_SVH
// ==========================================
// Packet geometry
`define TTX_DATA_525 6'd32
`define TTX_DATA_625 6'd40
`define TTX_TAB_COL 6'd32
`define TTX_TAB_BYTES 6'd8
`define TTX_PKT_TAB_LAST 5'd23
`define TTX_PKT_ROLL_LAST 5'd3
`define TTX_PKT_X24 5'd24
`define TTX_PKT_X26 5'd26
`define TTX_PKT_X27 5'd27
`define TTX_PKT_X30 5'd30
`define TTX_MAG_BSD_525 4'd4
`define TTX_MAG_BSD_625 4'd8
`define TTX_BSD_BYTES 6'd20
`define TTX_STAT_HALF 6'd12
`define TTX_STAT_LEN 6'd20
`define TTX_TRIP_LAST_525 6'd30
`define TTX_TRIP_LAST_625 6'd39
// ==========================================
// Memory placement
`define TTX_ROW24 5'd24
`define TTX_EXT_ROW_X24 5'd0
`define TTX_EXT_ROW_BSD 5'd2
`define TTX_EXT_ROW_STAT 5'd3
`define TTX_EXT_ROW_LINKS 5'd4
// ==========================================
// Standard detection and buffering
`define TTX_DET_FIELDS 4'd8
`define TTX_FIFO_WIDTH 10
`define TTX_FIFO_DEPTH 16
`endif

// [include/ttx_pkg.sv]
package ttx_pkg;
   typedef enum logic [0:0] {ST_IDLE, ST_DATA} ttx_state_e;
   typedef enum logic [2:0] {K_SKIP, K_ROW, K_TAB, K_X24, K_X124, K_X26, K_X27, K_X30} ttx_kind_e;
   typedef struct packed {
      ttx_state_e st;
      ttx_kind_e kind;
      logic [3:0] mag;
      logic tab;
      logic [4:0] pnum;
      logic pok;
      logic rok;
      logic [5:0] idx;
      logic [4:0] dc;
      logic [15:0] tacc;
      logic auto525;
      logic decided;
      logic [3:0] miss;
      logic seen;
      logic [1:0] force_prev;
      logic hi_det;
      logic lo_det;
      logic link_flag;
      logic we;
      logic ext;
      logic [4:0] row;
      logic [5:0] col;
      logic [7:0] data;
      logic tv;
      logic [4:0] tdc;
      logic [17:0] tdata;
      logic t625;
      logic s525;
   } ttx_acq_s;
endpackage : ttx_pkg

// [tb/ttx_acq_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Port checks for the acquisition block
module ttx_acq_properties (
   input wire logic clk_in, // Clock
   input wire logic sys_rst_in, // Reset
   input wire logic field_start_in, // Field pulse
   input wire logic force_select_hi_in, // Force high bit
   input wire logic force_select_lo_in, // Force low bit
   input wire logic row24_location_select_in, // Packet 24 placement
   input wire logic link_flag_clear_in, // Link clear
   input wire logic mem_we_out, // Write strobe
   input wire logic mem_ext_out, // Extension memory
   input wire logic [4:0] mem_row_out, // Row
   input wire logic trip_valid_out, // Triplet strobe
   input wire logic timing_625_out, // Timing
   input wire logic std_525_out, // Standard
   input wire logic std_high_line_detected_out, // 625 decided
   input wire logic std_low_line_detected_out, // 525 decided
   input wire logic link_detected_out // Link flag
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   wire logic [1:0] frc = {force_select_hi_in, force_select_lo_in};
   wire logic hi = std_high_line_detected_out;
   wire logic lo = std_low_line_detected_out;
   AST_FLAGS_EXCL: assert property (!(hi && lo))
      else $error("both detected flags set");
   AST_FORCED: assert property (frc != 2'h0 && $past(frc) == frc && !$past(sys_rst_in)
      |-> timing_625_out == frc[1] && std_525_out == (frc != 2'h2) && hi == (frc == 2'h2) && lo == (frc != 2'h2))
      else $error("forced selection not shown");
   AST_UNDECIDED: assert property (frc == 2'h0 && $past(frc) != 2'h0 |=> !hi && !lo)
      else $error("flags kept after return to automatic");
   AST_LINK_FALL: assert property ($fell(link_detected_out) |-> $past(link_flag_clear_in))
      else $error("link flag dropped without clear");
   // Decision lands one or two edges after its cause; a reset also resettles the flags
   AST_FLAG_CAUSE: assert property ($changed({hi, lo}) |-> $past(field_start_in) ||
      $past(field_start_in, 2) || $past(frc) != $past(frc, 2) || $past(sys_rst_in, 2))
      else $error("detected flag changed without cause");
   AST_X24_BASIC: assert property (mem_we_out && !mem_ext_out && mem_row_out == 5'h18
      |-> row24_location_select_in) else $error("basic row 24 written while unselected");
   AST_X24_EXT: assert property (mem_we_out && mem_ext_out && mem_row_out == 5'h00
      |-> !row24_location_select_in) else $error("extension row 0 written while unselected");
   AST_TRIP_GAP: assert property (trip_valid_out |=> !trip_valid_out [*2])
      else $error("triplets closer than three bytes");
   COV_TRIP: cover property (trip_valid_out);
   COV_LINK_CLEAR: cover property ($fell(link_detected_out));
   COV_DECIDED: cover property ($rose(hi));
endmodule : ttx_acq_properties

bind ttx_acq ttx_acq_properties ttx_acq_properties_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .field_start_in(field_start_in), .force_select_hi_in(force_select_hi_in),
   .force_select_lo_in(force_select_lo_in), .row24_location_select_in(row24_location_select_in),
   .link_flag_clear_in(link_flag_clear_in), .mem_we_out(mem_we_out), .mem_ext_out(mem_ext_out),
   .mem_row_out(mem_row_out), .trip_valid_out(trip_valid_out), .timing_625_out(timing_625_out),
   .std_525_out(std_525_out), .std_high_line_detected_out(std_high_line_detected_out),
   .std_low_line_detected_out(std_low_line_detected_out), .link_detected_out(link_detected_out));
`default_nettype wire

// [tb/ttx_slicer.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Slicer model: offers a packet word by word, holding each until taken
module ttx_slicer (
   input wire logic clk_in, // Clock
   input wire logic byte_ready_in, // FIFO has room
   output logic byte_valid_out, // Word offered
   output logic byte_first_out, // Address word
   output logic byte_page_ok_out, // Page requested
   output logic [7:0] byte_out // Word
);
   initial begin
      byte_valid_out = 1'b0;
      byte_first_out = 1'b0;
      byte_page_ok_out = 1'b0;
      byte_out = 8'h00;
   end
   task automatic send(input logic [7:0] addr, input logic ok, input int n, input logic [7:0] base);
      for (int k = -1; k < n; k++) begin
         @(negedge clk_in);
         byte_valid_out = 1'b1;
         byte_first_out = (k < 0);
         byte_page_ok_out = ok;
         byte_out = (k < 0) ? addr : base + 8'(k);
         do @(posedge clk_in); while (byte_ready_in !== 1'b1);
      end
      @(negedge clk_in);
      byte_valid_out = 1'b0;
      byte_first_out = 1'b0;
      // Released byte_out lines invert so stale data never looks valid
      byte_out = ~byte_out;
   endtask : send
endmodule : ttx_slicer
`default_nettype wire

// [tb/ttx_acq_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module ttx_acq_bench;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic byte_valid_in, byte_first_in, byte_page_ok_in, byte_ready_out;
   logic [7:0] byte_in;
   logic field_start_in = 1'b0;
   logic mem_wait_in = 1'b0;
   logic force_select_hi_in = 1'b0;
   logic force_select_lo_in = 1'b0;
   logic row24_location_select_in = 1'b1;
   logic raw_byte_mode_in = 1'b0;
   logic [1:0] page_check_in = 2'h0;
   logic parallel_mag_in = 1'b0;
   logic [3:0] mag_select_in = 4'h4;
   logic link_flag_clear_in = 1'b0;
   logic mem_we_out, mem_ext_out, trip_valid_out, timing_625_out, std_525_out, link_detected_out;
   logic std_high_line_detected_out, std_low_line_detected_out;
   logic [4:0] mem_row_out, trip_dc_out;
   logic [5:0] mem_col_out;
   logic [7:0] mem_data_out;
   logic [17:0] trip_data_out;
   int miscompares = 0;
   int comparisons = 0;
   int trips = 0;
   logic [7:0] mem [logic [11:0]];
   always #25 clk_in = ~clk_in;
   ttx_slicer ttx_slicer_i (.clk_in(clk_in), .byte_ready_in(byte_ready_out), .byte_valid_out(byte_valid_in),
      .byte_first_out(byte_first_in), .byte_page_ok_out(byte_page_ok_in), .byte_out(byte_in));
   ttx_acq ttx_acq_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .byte_valid_in(byte_valid_in),
      .byte_first_in(byte_first_in), .byte_page_ok_in(byte_page_ok_in), .byte_in(byte_in),
      .byte_ready_out(byte_ready_out), .field_start_in(field_start_in), .mem_wait_in(mem_wait_in),
      .force_select_hi_in(force_select_hi_in), .force_select_lo_in(force_select_lo_in),
      .row24_location_select_in(row24_location_select_in), .raw_byte_mode_in(raw_byte_mode_in),
      .page_check_in(page_check_in), .parallel_mag_in(parallel_mag_in), .mag_select_in(mag_select_in),
      .link_flag_clear_in(link_flag_clear_in), .mem_we_out(mem_we_out), .mem_ext_out(mem_ext_out),
      .mem_row_out(mem_row_out), .mem_col_out(mem_col_out), .mem_data_out(mem_data_out),
      .trip_valid_out(trip_valid_out), .trip_dc_out(trip_dc_out), .trip_data_out(trip_data_out),
      .timing_625_out(timing_625_out), .std_525_out(std_525_out),
      .std_high_line_detected_out(std_high_line_detected_out),
      .std_low_line_detected_out(std_low_line_detected_out), .link_detected_out(link_detected_out));
   always @(posedge clk_in) begin
      if (mem_we_out === 1'b1) mem[{mem_ext_out, mem_row_out, mem_col_out}] = mem_data_out;
      if (trip_valid_out === 1'b1) trips++;
   end
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   // Unwritten places read as unknown
   function automatic logic [7:0] rd(input logic e, input logic [4:0] r, input logic [5:0] c);
      return mem.exists({e, r, c}) ? mem[{e, r, c}] : 8'hxx;
   endfunction : rd
   task automatic pkt(input logic [7:0] addr, input logic ok, input int n, input logic [7:0] base);
      ttx_slicer_i.send(addr, ok, n, base);
      repeat (8) @(negedge clk_in);
   endtask : pkt
   task automatic fields(input int n);
      repeat (n) begin
         @(negedge clk_in);
         field_start_in = 1'b1;
         @(negedge clk_in);
         field_start_in = 1'b0;
      end
   endtask : fields
   task automatic results();
      if (miscompares == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge clk_in);
      miscompares++;
      results();
   end
   // ==========================================
   // Sequence
   initial begin
      repeat (4) @(negedge clk_in);
      sys_rst_in = 1'b0;
      repeat (2) @(negedge clk_in);
      check("flags at start", {6'h0, std_high_line_detected_out, std_low_line_detected_out}, 8'h0);
      fields(1);
      pkt(8'h25, 1'b1, 4, 8'h20);
      fields(1);
      repeat (2) @(negedge clk_in);
      check("decided", {6'h0, std_high_line_detected_out, std_low_line_detected_out}, 8'h2);
      fields(9);
      repeat (2) @(negedge clk_in);
      check("switched", {4'h0, std_high_line_detected_out, std_low_line_detected_out, timing_625_out,
         std_525_out}, 8'h1);
      for (int f = 1; f < 6; f++) begin
         {force_select_hi_in, force_select_lo_in} = 2'(f);
         repeat (3) @(negedge clk_in);
         check("selection", {4'h0, timing_625_out, std_525_out, std_high_line_detected_out,
            std_low_line_detected_out}, (f[1:0] == 2'h0) ? 8'h4 : {4'h0, f[1], f[1:0] != 2'h2, f[1:0] == 2'h2,
            f[1:0] != 2'h2});
      end
      // Full FIFO: memory stalled while a long packet arrives
      mem.delete();
      mem_wait_in = 1'b1;
      fork
         ttx_slicer_i.send(8'h05, 1'b1, 40, 8'h20);
         begin
            repeat (24) @(negedge clk_in);
            check("fifo full", {7'h0, byte_ready_out}, 8'h0);
            mem_wait_in = 1'b0;
         end
      join
      repeat (8) @(negedge clk_in);
      check("row start", rd(1'b0, 5'h05, 6'h00), 8'h20);
      check("row end", rd(1'b0, 5'h05, 6'h1f), 8'h3f);
      check("row beyond", rd(1'b0, 5'h05, 6'h20), 8'hxx);
      pkt(8'h89, 1'b1, 32, 8'h20);
      check("tab first", rd(1'b0, 5'h08, 6'h20), 8'h20);
      check("tab last", rd(1'b0, 5'h0b, 6'h27), 8'h3f);
      check("tab not magazine", rd(1'b0, 5'h09, 6'h00), 8'hxx);
      page_check_in = 2'h1;
      pkt(8'h8d, 1'b1, 2, 8'h20);
      check("odd parity", rd(1'b0, 5'h0c, 6'h20), 8'h20);
      check("even parity", rd(1'b0, 5'h0c, 6'h21), 8'hxx);
      raw_byte_mode_in = 1'b1;
      pkt(8'h8d, 1'b1, 2, 8'h20);
      check("raw byte", rd(1'b0, 5'h0c, 6'h21), 8'h21);
      raw_byte_mode_in = 1'b0;
      page_check_in = 2'h0;
      mem.delete();
      parallel_mag_in = 1'b1;
      pkt(8'ha2, 1'b0, 8, 8'h20);
      pkt(8'h80, 1'b0, 8, 8'h20);
      check("roll ignored", 8'(mem.size()), 8'h0);
      pkt(8'h81, 1'b0, 8, 8'h30);
      check("roll time", rd(1'b0, 5'h00, 6'h27), 8'h37);
      parallel_mag_in = 1'b0;
      for (int s = 0; s < 2; s++) begin
         mem.delete();
         row24_location_select_in = s[0];
         pkt(8'h18, 1'b1, 32, 8'h20);
         pkt(8'h98, 1'b1, 12, 8'h40);
         check("row 24", rd(~s[0], s[0] ? 5'h18 : 5'h00, 6'h00), 8'h20);
         check("prompt end", rd(~s[0], s[0] ? 5'h18 : 5'h00, 6'h27), 8'h47);
         check("prompt count", 8'(mem.size()), 8'h28);
      end
      mem.delete();
      pkt(8'h1b, 1'b1, 6, 8'h01);
      check("link flag", {7'h0, link_detected_out}, 8'h1);
      check("link data", rd(1'b1, 5'h04, 6'h00) & 8'h0f, 8'h01);
      link_flag_clear_in = 1'b1;
      @(negedge clk_in);
      link_flag_clear_in = 1'b0;
      mem.delete();
      pkt(8'h9b, 1'b1, 6, 8'h01);
      check("link clear", {7'h0, link_detected_out}, 8'h0);
      check("link dropped", 8'(mem.size()), 8'h0);
      pkt(8'h1e, 1'b1, 32, 8'h20);
      pkt(8'h9e, 1'b1, 40, 8'h41);
      check("service data", rd(1'b1, 5'h02, 6'h01) & 8'h0f, 8'h01);
      check("status first", rd(1'b1, 5'h03, 6'h0b), 8'h3f);
      check("status second", rd(1'b1, 5'h03, 6'h13), 8'h5c);
      check("status tail", rd(1'b1, 5'h03, 6'h14), 8'hxx);
      trips = 0;
      pkt(8'h9a, 1'b1, 32, 8'h03);
      check("triplets", 8'(trips), 8'h0a);
      check("designation", {3'h0, trip_dc_out}, 8'h11);
      check("triplet data", trip_data_out, 18'h08101);
      results();
   end
endmodule : ttx_acq_bench
`default_nettype wire
